// >>> hw/smrc_sequencer.v
// Standby-mode entry and release sequencer for the CPU core
//
// Summary of operation
// [RULE1] Edge mode: stop pin rising edge releases
// [RULE2] Edge mode: enter even if pin high
// [RULE3] Edge within one machine cycle ignored
// [RULE4] Key wake level releases, polarity selectable
// [RULE5] Key level return after warm-up ignored
// [RULE6] Low supply releases and asserts reset
// [RULE7] Supply back: reset off, warm-up, single-clock
// [RULE8] Supply back within one machine cycle ignored
// [RULE9] Release: oscillate, warm-up, clear dividers, resume
// [RULE10] Oscillators restart per mode before entry
// [RULE11] Dual-clock return feeds high clock to divider
// [RULE12] Warm-up source follows entry clock, not select
// [RULE13] CPU halt stops CPU and watchdog only
// [RULE14] Halt holds state; PC two ahead
// [RULE15] Writing halt bit enters CPU halt
// [RULE16] Pending release blocks halt entry
// [RULE17] Watchdog interrupt before entry blocks halt
// [RULE18] Halt release clears bit, restores mode
// [RULE19] Resets end halt; warm-up then single-clock
// [RULE20] Master disabled: latch ends halt, no service
// [RULE21] Master enabled: latch ends halt, service first
// [RULE22] Clock-gated halt keeps only time base
// [RULE23] Writing stop bit enters deep halt
// [RULE24] Level mode: release while stop pin high
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "smrc_regs.vh"

module smrc_sequencer #(
  parameter NUM_INT = 8
) (
  input  wire       REF_CLK,
  input  wire       SYS_RST,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR_STB,
  input  wire       RD_STB,
  output reg  [7:0] RDATA,
  input  wire       STOP_PIN_N,
  input  wire       KEY_WAKE,
  input  wire       SUPPLY_LOW,
  input  wire       WDT_INT,
  input  wire       MASTER_INT_ENABLE,
  input  wire       WARMUP_SRC_SEL,
  input  wire [NUM_INT-1:0] INT_EVENT,
  output reg        HIGH_OSC_EN,
  output reg        LOW_OSC_EN,
  output reg        CPU_RUN,
  output reg        WDT_RUN,
  output reg        PERIPH_CLK_EN,
  output reg        TIME_BASE_CLK_EN,
  output reg        DIVIDER_CLEAR,
  output reg        WARMUP_SRC_HIGH,
  output reg        WARMUP_ACTIVE,
  output reg        VD_RESET,
  output reg        SERVICE_INT,
  output reg        RESUME_PULSE,
  output reg  [1:0] PC_ADVANCE
);

  // ******************************************************************
  // States and modes
  // ******************************************************************
  localparam ST_RUN    = 3'd0;
  localparam ST_DEEP   = 3'd1;
  localparam ST_WARMUP = 3'd2;
  localparam ST_HALT   = 3'd3;
  localparam ST_GATED  = 3'd4;
  localparam ST_VDRST  = 3'd5;

  localparam MODE_SINGLE = 2'd0;
  localparam MODE_DUAL   = 2'd1;
  localparam MODE_SLOW   = 2'd2;

  // Guard spans one machine cycle plus the pin synchroniser delay,
  // so an edge that hit the pin inside the window is still refused
  localparam [3:0] GUARD_LOAD = `SMRC_MACHINE_CYCLES + `SMRC_PIN_LATENCY;

  // ******************************************************************
  // Registers
  // ******************************************************************
  reg [2:0]         state;
  reg [7:0]         sysctl1;
  reg [7:0]         sysctl2;
  reg [7:0]         warmup_count_value;
  reg [7:0]         warmup_ctr;
  reg [7:0]         key_ctrl;
  reg [NUM_INT-1:0] int_enable_flag;
  reg [NUM_INT-1:0] int_request_latch;
  reg [1:0]         entry_mode;
  reg [3:0]         guard_ctr;
  reg [2:0]         stop_sync;
  reg [2:0]         key_sync;
  reg [2:0]         vd_sync;
  reg               stop_level;
  reg               key_level;
  reg               vd_level;
  reg               stop_level_d;
  reg               vd_level_d;
  reg               wdt_int_d;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Level follows the chain only once stages two and three agree
  function smrc_settle(input [2:0] chain, input held);
    smrc_settle = (chain[1] == chain[2]) ? chain[2] : held;
  endfunction

  // Write strobe aimed at one register index
  function smrc_wr_hit(input stb, input [3:0] a, input [3:0] idx);
    smrc_wr_hit = stb && (a == idx);
  endfunction

  // Operating mode from the second control register
  function [1:0] smrc_mode(input [7:0] sc2);
    smrc_mode = sc2[`SMRC_SC2_SYSCK] ? MODE_SLOW :
                (sc2[`SMRC_SC2_XTEN] ? MODE_DUAL : MODE_SINGLE);
  endfunction

  // ******************************************************************
  // Write decode
  // ******************************************************************
  wire       wr_sc1   = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_SYSCTL1);
  wire       wr_sc2   = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_SYSCTL2);
  wire       wr_wuc   = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_WARMUP_CNT);
  wire       wr_ie    = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_INT_ENABLE);
  wire       wr_il    = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_INT_LATCH);
  wire       wr_key   = smrc_wr_hit(WR_STB, ADDR, `SMRC_ADDR_KEY_CTRL);

  // ******************************************************************
  // Entry and release conditions
  // ******************************************************************
  wire [1:0] cur_mode  = smrc_mode(sysctl2);
  wire       guarded   = (guard_ctr != 4'd0);
  wire       stop_rise = stop_level && !stop_level_d;
  wire       vd_rise   = !vd_level && vd_level_d;
  wire       key_hit   = key_ctrl[`SMRC_KEY_EN] &&
                         (key_level == key_ctrl[`SMRC_KEY_LEVEL]);
  wire       int_hit   = |(int_request_latch & int_enable_flag);
  wire       vd_armed  = key_ctrl[`SMRC_KEY_VD_RESET];
  // Edge release is blind while the guard runs
  wire       edge_release  = !sysctl1[`SMRC_SC1_STOP_RELEASE_MODE_SEL] && stop_rise && !guarded;
  wire       level_release = sysctl1[`SMRC_SC1_STOP_RELEASE_MODE_SEL] && stop_level;
  // A watchdog interrupt this cycle or the last one blocks halt entry
  wire       wdt_block     = WDT_INT || wdt_int_d;

  // ******************************************************************
  // Pin synchronisers: change counts once stages two and three agree
  // ******************************************************************
  // Stop pin resets high, its idle level, so no false edge after reset
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stop_sync  <= 3'h7;
      key_sync   <= 3'h0;
      vd_sync    <= 3'h0;
      stop_level <= 1'b1;
      key_level  <= 1'b0;
      vd_level   <= 1'b0;
    end else begin
      stop_sync <= {stop_sync[1:0], STOP_PIN_N};
      key_sync  <= {key_sync[1:0], KEY_WAKE};
      vd_sync   <= {vd_sync[1:0], SUPPLY_LOW};
      stop_level <= smrc_settle(stop_sync, stop_level);
      key_level  <= smrc_settle(key_sync, key_level);
      vd_level   <= smrc_settle(vd_sync, vd_level);
    end
  end

  // ******************************************************************
  // Main sequencer
  // ******************************************************************
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state              <= ST_WARMUP;
      sysctl1            <= `SMRC_SC1_RESET;
      sysctl2            <= `SMRC_SC2_RESET;
      warmup_count_value <= `SMRC_WARMUP_RESET;
      warmup_ctr         <= `SMRC_WARMUP_RESET;
      key_ctrl           <= 8'h00;
      int_enable_flag    <= {NUM_INT{1'b0}};
      int_request_latch  <= {NUM_INT{1'b0}};
      entry_mode         <= MODE_SINGLE;
      guard_ctr          <= 4'd0;
      stop_level_d       <= 1'b1;
      vd_level_d         <= 1'b0;
      wdt_int_d          <= 1'b0;
      RESUME_PULSE       <= 1'b0;
      SERVICE_INT        <= 1'b0;
    end else begin
      stop_level_d <= stop_level;
      vd_level_d   <= vd_level;
      wdt_int_d    <= WDT_INT;
      RESUME_PULSE <= 1'b0;
      SERVICE_INT  <= 1'b0;
      if (guarded)
        guard_ctr <= guard_ctr - 4'd1;
      // Event set wins over a software clear in the same cycle
      if (wr_il)
        int_request_latch <= (int_request_latch & WDATA[NUM_INT-1:0]) | INT_EVENT;
      else
        int_request_latch <= int_request_latch | INT_EVENT;
      if (wr_wuc)
        warmup_count_value <= WDATA;
      if (wr_ie)
        int_enable_flag <= WDATA[NUM_INT-1:0];
      if (wr_key)
        key_ctrl <= WDATA;
      case (state)
        ST_RUN: begin
          if (wr_sc1) begin
            sysctl1 <= WDATA;
            if (WDATA[`SMRC_SC1_STOP] &&
                (WDATA[`SMRC_SC1_STOP_RELEASE_MODE_SEL] ? !stop_level : 1'b1)) begin // see [RULE2]
              state      <= ST_DEEP;                              // see [RULE23]
              entry_mode <= cur_mode;
              guard_ctr  <= GUARD_LOAD;                           // see [RULE3] [RULE8]
            end else begin
              sysctl1[`SMRC_SC1_STOP] <= 1'b0;
            end
          end else if (wr_sc2) begin
            sysctl2 <= WDATA;
            sysctl2[`SMRC_SC2_HALT] <= 1'b0;
            sysctl2[`SMRC_SC2_GATE] <= 1'b0;
            // Halt bit stays clear if already releasable
            if (WDATA[`SMRC_SC2_HALT] && !int_hit && !wdt_block) begin // see [RULE16] [RULE17]
              sysctl2[`SMRC_SC2_HALT] <= 1'b1;                    // see [RULE15]
              state <= ST_HALT;
            end else if (WDATA[`SMRC_SC2_GATE] && !int_hit && !wdt_block) begin
              sysctl2[`SMRC_SC2_GATE] <= 1'b1;
              state <= ST_GATED;
            end
          end
        end
        ST_DEEP: begin
          if (vd_armed && vd_level) begin
            state <= ST_VDRST;                                    // see [RULE6]
          end else if (edge_release ||                            // see [RULE1] [RULE3]
                       level_release ||                           // see [RULE24]
                       key_hit) begin                             // see [RULE4]
            state      <= ST_WARMUP;                              // see [RULE9]
            warmup_ctr <= warmup_count_value;
          end
        end
        ST_VDRST: begin
          // Rise during the guard window keeps the deep halt
          if (vd_rise && guarded && !vd_level) begin              // see [RULE8]
            state <= ST_DEEP;
          end else if (!vd_level) begin
            state      <= ST_WARMUP;                              // see [RULE7]
            entry_mode <= MODE_SINGLE;
            sysctl1    <= `SMRC_SC1_RESET;
            sysctl2    <= `SMRC_SC2_RESET;
            warmup_ctr <= warmup_count_value;
          end
        end
        ST_WARMUP: begin
          // Key pin no longer watched here, so no re-entry
          if (warmup_ctr == 8'h00) begin                          // see [RULE5]
            state   <= ST_RUN;
            sysctl1[`SMRC_SC1_STOP] <= 1'b0;
            RESUME_PULSE <= 1'b1;
          end else begin
            warmup_ctr <= warmup_ctr - 8'h01;
          end
        end
        ST_HALT: begin
          if (int_hit) begin
            state <= ST_RUN;
            sysctl2[`SMRC_SC2_HALT] <= 1'b0;                      // see [RULE18]
            RESUME_PULSE <= 1'b1;
            SERVICE_INT  <= MASTER_INT_ENABLE;                    // see [RULE20] [RULE21]
          end
        end
        ST_GATED: begin
          // Simplified: woken by an enabled latch, not the time base edge
          if (int_hit) begin
            state <= ST_RUN;
            sysctl2[`SMRC_SC2_GATE] <= 1'b0;
            RESUME_PULSE <= 1'b1;
            SERVICE_INT  <= MASTER_INT_ENABLE;
          end
        end
        default: begin
          state <= ST_WARMUP;
        end
      endcase
      if (state != ST_VDRST && state != ST_DEEP && vd_armed && vd_level) begin
        state <= ST_VDRST;                                        // see [RULE19]
      end
    end
  end

  // ******************************************************************
  // Clock and run controls, all registered
  // ******************************************************************
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      HIGH_OSC_EN      <= 1'b1;
      LOW_OSC_EN       <= 1'b0;
      CPU_RUN          <= 1'b0;
      WDT_RUN          <= 1'b0;
      PERIPH_CLK_EN    <= 1'b0;
      TIME_BASE_CLK_EN <= 1'b0;
      DIVIDER_CLEAR    <= 1'b1;
      WARMUP_SRC_HIGH  <= 1'b1;
      WARMUP_ACTIVE    <= 1'b1;
      VD_RESET         <= 1'b0;
      PC_ADVANCE       <= 2'd0;
    end else begin
      VD_RESET      <= (state == ST_VDRST);                       // see [RULE6]
      WARMUP_ACTIVE <= (state == ST_WARMUP);
      // Internal logic frozen during warm-up; dividers held clear
      CPU_RUN       <= (state == ST_RUN);                         // see [RULE9] [RULE13]
      WDT_RUN       <= (state == ST_RUN);
      PERIPH_CLK_EN <= (state == ST_RUN) || (state == ST_HALT);   // see [RULE22]
      TIME_BASE_CLK_EN <= (state == ST_RUN) || (state == ST_HALT) ||
                          (state == ST_GATED);
      DIVIDER_CLEAR <= (state == ST_DEEP) || (state == ST_WARMUP) ||
                       (state == ST_VDRST);
      // Two ahead of the entry instruction while halted
      PC_ADVANCE <= (state == ST_HALT || state == ST_GATED ||
                     state == ST_DEEP) ? 2'd2 : 2'd0;             // see [RULE14]
      case (state)
        ST_DEEP, ST_VDRST: begin
          HIGH_OSC_EN <= 1'b0;                                    // see [RULE23]
          LOW_OSC_EN  <= 1'b0;
        end
        ST_WARMUP: begin
          HIGH_OSC_EN <= (entry_mode != MODE_SLOW);               // see [RULE10]
          LOW_OSC_EN  <= (entry_mode != MODE_SINGLE);
        end
        default: begin
          HIGH_OSC_EN <= sysctl2[`SMRC_SC2_XEN];
          LOW_OSC_EN  <= sysctl2[`SMRC_SC2_XTEN];
        end
      endcase
      // Entry clock picks warm-up source; select ignored then
      if (state == ST_WARMUP)
        WARMUP_SRC_HIGH <= (entry_mode != MODE_SLOW);             // see [RULE11] [RULE12]
      else
        WARMUP_SRC_HIGH <= !WARMUP_SRC_SEL;
    end
  end

  // ******************************************************************
  // Register read port
  // ******************************************************************
  // Data stand one cycle only, zero otherwise, so stale reads show up
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        `SMRC_ADDR_SYSCTL1:    RDATA <= sysctl1;
        `SMRC_ADDR_SYSCTL2:    RDATA <= sysctl2;
        `SMRC_ADDR_WARMUP_CNT: RDATA <= warmup_count_value;
        `SMRC_ADDR_INT_ENABLE: RDATA <= int_enable_flag;
        `SMRC_ADDR_INT_LATCH:  RDATA <= int_request_latch;
        `SMRC_ADDR_STATUS:     RDATA <= {key_level, stop_level, vd_level, 2'b00, state};
        `SMRC_ADDR_KEY_CTRL:   RDATA <= key_ctrl;
        default:               RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule

// >>> hw/smrc_regs.vh
// Register offsets, field positions, reset values and timing counts for the standby sequencer
`ifndef SMRC_REGS_VH
`define SMRC_REGS_VH
// Register indices on the plain register port
`define SMRC_ADDR_SYSCTL1     4'h0
`define SMRC_ADDR_SYSCTL2     4'h1
`define SMRC_ADDR_WARMUP_CNT  4'h2
`define SMRC_ADDR_INT_ENABLE  4'h3
`define SMRC_ADDR_INT_LATCH   4'h4
`define SMRC_ADDR_STATUS      4'h5
`define SMRC_ADDR_KEY_CTRL    4'h6
// system_control_first fields
`define SMRC_SC1_STOP         7
`define SMRC_SC1_STOP_RELEASE_MODE_SEL         6
// system_control_second fields
`define SMRC_SC2_XEN          6
`define SMRC_SC2_XTEN         5
`define SMRC_SC2_SYSCK        4
`define SMRC_SC2_HALT         3
`define SMRC_SC2_GATE         2
// Key control fields
`define SMRC_KEY_EN           0
`define SMRC_KEY_LEVEL        1
`define SMRC_KEY_VD_RESET     2
// Reset values
`define SMRC_SC1_RESET        8'h00
`define SMRC_SC2_RESET        8'h40
`define SMRC_WARMUP_RESET     8'h20
// One machine cycle, in clock cycles
`define SMRC_MACHINE_CYCLES   4'd4
// Clocks from a pin change to the edge seen by the sequencer
`define SMRC_PIN_LATENCY      4'd5
`define SMRC_PC_HALT_OFFSET   16'h0002
`endif

// >>> tb/smrc_seq_chk.sv
// Concurrent checks on the standby sequencer ports
`timescale 1ns/1ps
module smrc_seq_chk (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic MASTER_INT_ENABLE,
  input wire logic HIGH_OSC_EN,
  input wire logic LOW_OSC_EN,
  input wire logic CPU_RUN,
  input wire logic WDT_RUN,
  input wire logic PERIPH_CLK_EN,
  input wire logic TIME_BASE_CLK_EN,
  input wire logic WARMUP_SRC_HIGH,
  input wire logic WARMUP_ACTIVE,
  input wire logic VD_RESET,
  input wire logic SERVICE_INT,
  input wire logic RESUME_PULSE
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  a_wdt_stops_too: assert property (!CPU_RUN |-> !WDT_RUN)
    else $error("watchdog runs while cpu stopped");
  a_warmup_no_cpu: assert property (WARMUP_ACTIVE |-> !CPU_RUN)
    else $error("cpu runs during warm-up");
  a_osc_off_still: assert property (!HIGH_OSC_EN && !LOW_OSC_EN |-> !CPU_RUN && !PERIPH_CLK_EN)
    else $error("logic runs with both oscillators off");
  a_tb_kept_on: assert property (PERIPH_CLK_EN |-> TIME_BASE_CLK_EN)
    else $error("time base gated while peripherals clocked");
  a_warm_src_high: assert property (WARMUP_ACTIVE && !LOW_OSC_EN |-> WARMUP_SRC_HIGH)
    else $error("warm-up source not the high clock");
  a_service_needs_ime: assert property (SERVICE_INT |-> $past(MASTER_INT_ENABLE))
    else $error("interrupt serviced with master enable off");
  a_resume_one_cycle: assert property (RESUME_PULSE |=> !RESUME_PULSE)
    else $error("resume pulse longer than one cycle");
  a_vd_holds_cpu: assert property (VD_RESET |-> !CPU_RUN)
    else $error("cpu runs during detector reset");
  a_warm_then_run: assert property ($fell(WARMUP_ACTIVE) |-> ##[0:2] CPU_RUN)
    else $error("no run after warm-up");
  c_resume: cover property (RESUME_PULSE);
endmodule

bind smrc_sequencer smrc_seq_chk chk_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .MASTER_INT_ENABLE(MASTER_INT_ENABLE), .HIGH_OSC_EN(HIGH_OSC_EN), .LOW_OSC_EN(LOW_OSC_EN),
  .CPU_RUN(CPU_RUN), .WDT_RUN(WDT_RUN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .TIME_BASE_CLK_EN(TIME_BASE_CLK_EN), .WARMUP_SRC_HIGH(WARMUP_SRC_HIGH),
  .WARMUP_ACTIVE(WARMUP_ACTIVE), .VD_RESET(VD_RESET), .SERVICE_INT(SERVICE_INT),
  .RESUME_PULSE(RESUME_PULSE));

// >>> tb/smrc_pins.sv
// Model of the wake pins and supply detector outside the sequencer
`timescale 1ns/1ps
module smrc_pins (
  input  wire logic REF_CLK,
  output logic      STOP_PIN_N,
  output logic      KEY_WAKE,
  output logic      SUPPLY_LOW
);
  // ****************************************
  // Pin levels
  // ****************************************
  // Stop pin idles high, key low, supply good; changed only after an edge
  initial begin
    STOP_PIN_N = 1'b1;
    KEY_WAKE   = 1'b0;
    SUPPLY_LOW = 1'b0;
  end
  task automatic drive(input logic stop_n, input logic key, input logic low);
    @(posedge REF_CLK);
    STOP_PIN_N <= stop_n;
    KEY_WAKE   <= key;
    SUPPLY_LOW <= low;
  endtask
endmodule

// >>> tb/tb_standby_mode_release_control.sv
// Self-checking bench for the standby sequencer
`timescale 1ns/1ps
`include "smrc_regs.vh"
module tb_standby_mode_release_control;
  // ****************************************
  // Signals
  // ****************************************
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] addr    = 4'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic       mie     = 1'b0;
  logic       wdt_irq = 1'b0;
  logic [7:0] int_ev  = 8'h00;
  logic       svc_seen;
  int         bad_count = 0;
  int         n_checks  = 0;
  wire  [7:0] rdata;
  wire        stop_n, key, low, hosc, losc, run, wdt, pclk, svc, vd, dclr;
  wire  [1:0] pca;
  always #10 ref_clk = ~ref_clk;
  smrc_pins pins_u (.REF_CLK(ref_clk), .STOP_PIN_N(stop_n), .KEY_WAKE(key), .SUPPLY_LOW(low));
  smrc_sequencer dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .STOP_PIN_N(stop_n), .KEY_WAKE(key),
    .SUPPLY_LOW(low), .WDT_INT(wdt_irq), .MASTER_INT_ENABLE(mie), .WARMUP_SRC_SEL(1'b1),
    .INT_EVENT(int_ev), .HIGH_OSC_EN(hosc), .LOW_OSC_EN(losc), .CPU_RUN(run), .WDT_RUN(wdt),
    .PERIPH_CLK_EN(pclk), .TIME_BASE_CLK_EN(), .DIVIDER_CLEAR(dclr), .WARMUP_SRC_HIGH(),
    .WARMUP_ACTIVE(), .VD_RESET(vd), .SERVICE_INT(svc), .RESUME_PULSE(), .PC_ADVANCE(pca));
  always @(posedge ref_clk) if (svc === 1'b1) svc_seen <= 1'b1;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // Bounded wait, a run-out shows as a mismatch
  task automatic wait_run(input logic v);
    int i;
    for (i = 0; i < 400 && run !== v; i++) @(posedge ref_clk);
    #1 check({7'h0, run}, {7'h0, v});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Halt, wake by latch 0, expect service only with master enable
  task automatic halt_wake(input logic m);
    mie <= m; svc_seen <= 1'b0;
    wr(`SMRC_ADDR_SYSCTL2, 8'h48);
    idle(4);
    check({run, wdt, pclk}, 8'h01);
    check({6'h0, pca}, 8'h02);
    @(posedge ref_clk) int_ev <= 8'h01;
    @(posedge ref_clk) int_ev <= 8'h00;
    wait_run(1'b1);
    idle(4);
    check({7'h0, svc_seen}, {7'h0, m});
    rd(`SMRC_ADDR_SYSCTL2, 8'h40);
    wr(`SMRC_ADDR_INT_LATCH, 8'h00);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    svc_seen = 1'b0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_run(1'b1);
    rd(`SMRC_ADDR_SYSCTL1, 8'h00);
    rd(`SMRC_ADDR_SYSCTL2, 8'h40);
    rd(`SMRC_ADDR_WARMUP_CNT, 8'h20);
    rd(4'hf, 8'h00);
    // Edge mode entered with the pin already high
    wr(`SMRC_ADDR_SYSCTL1, 8'h80);
    idle(4);
    check({run, hosc, losc}, 8'h00);
    check({7'h0, dclr}, 8'h01);
    pins_u.drive(1'b0, 1'b0, 1'b0);
    idle(8);
    pins_u.drive(1'b1, 1'b0, 1'b0);
    wait_run(1'b1);
    check({hosc, losc}, 8'h02);
    // Edge right after the command is blind
    pins_u.drive(1'b0, 1'b0, 1'b0);
    idle(8);
    wr(`SMRC_ADDR_SYSCTL1, 8'h80);
    pins_u.drive(1'b1, 1'b0, 1'b0);
    idle(30);
    check({7'h0, run}, 8'h00);
    // Key release at high level, then key drops
    wr(`SMRC_ADDR_KEY_CTRL, 8'h03);
    pins_u.drive(1'b1, 1'b1, 1'b0);
    wait_run(1'b1);
    pins_u.drive(1'b1, 1'b0, 1'b0);
    idle(60);
    check({7'h0, run}, 8'h01);
    // Cpu halt with master enable off, then on
    wr(`SMRC_ADDR_INT_ENABLE, 8'h01);
    halt_wake(1'b0);
    halt_wake(1'b1);
    // Latch pending at entry blocks the halt
    mie <= 1'b0;
    @(posedge ref_clk) int_ev <= 8'h01;
    @(posedge ref_clk) int_ev <= 8'h00;
    wr(`SMRC_ADDR_SYSCTL2, 8'h48);
    idle(4);
    check({7'h0, run}, 8'h01);
    rd(`SMRC_ADDR_SYSCTL2, 8'h40);
    wr(`SMRC_ADDR_INT_LATCH, 8'h00);
    // Watchdog interrupt at the entry write blocks the halt
    wdt_irq <= 1'b1;
    wr(`SMRC_ADDR_SYSCTL2, 8'h48);
    wdt_irq <= 1'b0;
    idle(4);
    check({7'h0, run}, 8'h01);
    rd(`SMRC_ADDR_SYSCTL2, 8'h40);
    // Detector reset out of deep halt
    wr(`SMRC_ADDR_KEY_CTRL, 8'h04);
    wr(`SMRC_ADDR_SYSCTL1, 8'h80);
    idle(8);
    pins_u.drive(1'b1, 1'b0, 1'b1);
    idle(8);
    check({7'h0, vd}, 8'h01);
    pins_u.drive(1'b1, 1'b0, 1'b0);
    wait_run(1'b1);
    check({vd, hosc, losc}, 8'h02);
    finish_test;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
endmodule
